//--- hw/chain_link_defines.svh
// Command codes, field positions and reset values of the chain link
`ifndef CHAIN_LINK_DEFINES_SVH
`define CHAIN_LINK_DEFINES_SVH

// Command codes carried in the first character of a packet
`define CMD_READ        8'h01
`define CMD_READ_ALL    8'h02
`define CMD_BLOCK_READ  8'h03
`define CMD_WRITE       8'h04
`define CMD_WRITE_ALL   8'h05
`define CMD_CLAIM_UP    8'h06
`define CMD_CLAIM_DOWN  8'h07

// Character sent on the down path while in alert topology
`define ALERT_CHAR      8'hae

// Packet layout: command, address, data
`define PKT_LEN         2'h3
`define POS_ADDR        2'h1
`define POS_DATA        2'h2
`define POS_DONE        2'h3

// Write data fields
`define WD_TOPO_LSB     0
`define WD_TOPO_MSB     1
`define WD_CLR_ALERT    2

// Status byte fields returned by a single read
`define ST_TOPO_LSB     0
`define ST_ALERT        2
`define ST_MASTER       3

// Reset values
`define RST_TOPOLOGY    2'h0
`define RST_MASTER_DOWN 1'b0
`define RST_ALERT       1'b0
`define ADDR_W          5

`endif

//--- hw/chain_pkg.sv
// Types and command decoding shared by both ends of the chain link
package chain_pkg;
  `include "chain_link_defines.svh"

  typedef logic [7:0] char_t;
  typedef logic [`ADDR_W-1:0] dev_addr_t;

  // Declaration order gives the codes 0b00 to 0b11
  typedef enum logic [1:0] {
    TOPO_EXT_LOOP,
    TOPO_INT_LOOP,
    TOPO_ALERT,
    TOPO_DUAL
  } topology_t;

  function automatic logic is_write(input char_t cmd);
    return (cmd == `CMD_WRITE) || (cmd == `CMD_WRITE_ALL);
  endfunction

  function automatic logic is_broadcast(input char_t cmd);
    return (cmd == `CMD_WRITE_ALL) || (cmd == `CMD_READ_ALL) ||
           (cmd == `CMD_BLOCK_READ);
  endfunction
endpackage

//--- hw/chain_link_if.sv
// Character link between the host controller and the lowest device
`timescale 1ns/1ps
interface chain_link_if;
  logic                 h2d_valid;  // Host to device character valid
  logic                 h2d_sop;    // First character of a packet
  chain_pkg::char_t     h2d_data;   // Host to device character
  logic                 d2h_valid;  // Device to host character valid
  logic                 d2h_sop;    // First character of a packet
  chain_pkg::char_t     d2h_data;   // Device to host character

  modport device (
    input  h2d_valid, h2d_sop, h2d_data,
    output d2h_valid, d2h_sop, d2h_data
  );
  modport host (
    output h2d_valid, h2d_sop, h2d_data,
    input  d2h_valid, d2h_sop, d2h_data
  );
endinterface

//--- hw/chain_device.sv
// Daisy-chain device: up and down path routing with topology control
`timescale 1ns/1ps
`include "chain_link_defines.svh"
module chain_device (
  input  wire logic                 CORE_CLK,          // Core clock
  input  wire logic                 RST,               // Sync reset
  chain_link_if.device              LINK,              // Lower port
  input  wire chain_pkg::dev_addr_t DEV_ADDR,          // Chain address
  input  wire logic                 RXU_VALID,         // Upper rx valid
  input  wire logic                 RXU_SOP,           // Upper rx start
  input  wire chain_pkg::char_t     RXU_DATA,          // Upper rx char
  output logic                      TXU_VALID,         // Upper tx valid
  output logic                      TXU_SOP,           // Upper tx start
  output chain_pkg::char_t          TXU_DATA,          // Upper tx char
  output chain_pkg::topology_t      LINK_TOPOLOGY,     // Topology select
  output logic                      SLAVE_WRITE_ALERT, // Sticky alert
  output logic                      MASTER_PATH_FLAG   // 1: down master
);
  import chain_pkg::*;

  // Path 0 is the up path, path 1 the down path
  topology_t   topo_r;
  logic        master_down_r;
  logic        alert_r;
  logic [1:0]  in_v;
  logic [1:0]  in_sop;
  char_t       in_d      [2];
  logic [1:0]  out_v_r;
  logic [1:0]  out_sop_r;
  char_t       out_d_r   [2];
  char_t       cmd_r     [2];
  dev_addr_t   addr_r    [2];
  logic [1:0]  pos_r     [2];
  logic [1:0]  wr_ok;
  logic [1:0]  set_alert;
  logic [1:0]  claim_up;
  logic [1:0]  claim_dn;
  char_t       status_byte;

  // Status returned to a single read addressed to this device
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_TOPO_LSB +: 2] = topo_r;
    status_byte[`ST_ALERT] = alert_r;
    status_byte[`ST_MASTER] = master_down_r;
  end

  // Up path always takes the lower receive port
  always_comb begin
    in_v[0] = LINK.h2d_valid;
    in_sop[0] = LINK.h2d_sop;
    in_d[0] = LINK.h2d_data;
  end

  // Down path source depends on topology
  always_comb begin
    unique case (topo_r)
      TOPO_INT_LOOP: begin
        // Upper pins ignored; our own upper transmit comes back
        in_v[1] = out_v_r[0];
        in_sop[1] = out_sop_r[0];
        in_d[1] = out_d_r[0];
      end
      TOPO_ALERT: begin
        // Alert level sent as a repeated alert character
        in_v[1] = alert_r;
        in_sop[1] = 1'b1;
        in_d[1] = `ALERT_CHAR;
      end
      default: begin
        // External loopback or dual path: real upper pins
        in_v[1] = RXU_VALID;
        in_sop[1] = RXU_SOP;
        in_d[1] = RXU_DATA;
      end
    endcase
  end

  // One identical parser and forwarder per path
  for (genvar p = 0; p < 2; p++) begin : g_path
    localparam bit IS_DOWN = (p == 1);
    logic  last;
    logic  hit;
    logic  exec;
    logic  master;
    logic  subst;

    // Down path only acts on commands when it is a second path
    assign exec = !IS_DOWN || (topo_r == TOPO_DUAL);
    assign master = (IS_DOWN == master_down_r);
    assign last = in_v[p] && !in_sop[p] && (pos_r[p] == `POS_DATA);
    // Five address bits reach 32 devices
    assign hit = is_broadcast(cmd_r[p]) || (addr_r[p] == DEV_ADDR);
    // The up path, and the down path in dual topology, answers a read, master or slave
    assign subst = last && exec && (cmd_r[p] == `CMD_READ) &&
                   (addr_r[p] == DEV_ADDR);

    // Writes run only on the master path
    assign wr_ok[p] = last && exec && is_write(cmd_r[p]) && hit &&
                      master;
    // Slave write or misplaced claim-up raises the alert
    assign set_alert[p] = last && exec &&
      ((is_write(cmd_r[p]) && hit && !master) ||
       (IS_DOWN && (cmd_r[p] == `CMD_CLAIM_UP)));
    assign claim_up[p] = last && !IS_DOWN &&
                         (cmd_r[p] == `CMD_CLAIM_UP);
    assign claim_dn[p] = last && exec && IS_DOWN &&
                         (cmd_r[p] == `CMD_CLAIM_DOWN);

    // Packet position tracking
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        pos_r[p] <= `POS_DONE;
        cmd_r[p] <= 8'h00;
        addr_r[p] <= '0;
      end else if (in_v[p]) begin
        if (in_sop[p]) begin
          pos_r[p] <= `POS_ADDR;
          cmd_r[p] <= in_d[p];
        end else if (pos_r[p] == `POS_ADDR) begin
          pos_r[p] <= `POS_DATA;
          addr_r[p] <= in_d[p][`ADDR_W-1:0];
        end else begin
          pos_r[p] <= `POS_DONE;
        end
      end
    end

    // One-cycle retransmit; every character is forwarded, writes too
    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        out_v_r[p] <= 1'b0;
        out_sop_r[p] <= 1'b0;
        out_d_r[p] <= 8'h00;
      end else begin
        out_v_r[p] <= in_v[p];
        out_sop_r[p] <= in_sop[p];
        // Only an addressed read alters a character; up path output only follows
        // input, even in alert topology; the alert characters go out on the down path only
        out_d_r[p] <= subst ? status_byte : in_d[p];
      end
    end
  end

  // Topology write takes effect on the data character itself
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      topo_r <= topology_t'(`RST_TOPOLOGY);
    end else if (wr_ok[0]) begin
      topo_r <= topology_t'(in_d[0][`WD_TOPO_MSB:`WD_TOPO_LSB]);
    end else if (wr_ok[1]) begin
      topo_r <= topology_t'(in_d[1][`WD_TOPO_MSB:`WD_TOPO_LSB]);
    end
  end

  // Master selection; claim-down wins a simultaneous claim-up
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      master_down_r <= `RST_MASTER_DOWN;
    end else if (|claim_dn) begin
      master_down_r <= 1'b1;
    end else if (|claim_up) begin
      master_down_r <= 1'b0;
    end
  end

  // Sticky alert; a new event beats a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      alert_r <= `RST_ALERT;
    end else if (|set_alert) begin
      alert_r <= 1'b1;
    end else if ((wr_ok[0] && in_d[0][`WD_CLR_ALERT]) ||
                 (wr_ok[1] && in_d[1][`WD_CLR_ALERT])) begin
      alert_r <= 1'b0;
    end
  end

  // Ports driven straight from the path and state flops
  assign LINK.d2h_valid = out_v_r[1];
  assign LINK.d2h_sop = out_sop_r[1];
  assign LINK.d2h_data = out_d_r[1];
  assign TXU_VALID = out_v_r[0];
  assign TXU_SOP = out_sop_r[0];
  assign TXU_DATA = out_d_r[0];
  assign LINK_TOPOLOGY = topo_r;
  assign SLAVE_WRITE_ALERT = alert_r;
  assign MASTER_PATH_FLAG = master_down_r;

endmodule // chain_device

//--- hw/chain_host.sv
// Host link controller: sends command packets and collects answers
`timescale 1ns/1ps
`include "chain_link_defines.svh"
module chain_host (
  input  wire logic                 CORE_CLK,    // Core clock
  input  wire logic                 RST,         // Sync reset
  chain_link_if.host                LINK,        // Link to lowest device
  input  wire logic                 CMD_VALID,   // Command request
  input  wire chain_pkg::char_t     CMD_CODE,    // Command code
  input  wire chain_pkg::dev_addr_t CMD_ADDR,    // Target address
  input  wire chain_pkg::char_t     CMD_DATA,    // Write data
  input  wire logic                 DUAL_WIRED,  // Board wired dual
  output logic                      CMD_READY,   // Idle, may accept
  output logic                      CMD_REFUSED, // Pulse: refused
  output logic                      RX_VALID,    // Pulse: answer byte
  output chain_pkg::char_t          RX_DATA,     // Third returned char
  output logic                      RX_FLUSH     // Pulse: rx flushed
);
  import chain_pkg::*;

  typedef enum logic {ST_IDLE, ST_SEND} host_state_t;

  host_state_t state_r;
  char_t       code_r;
  char_t       addr_r;
  char_t       data_r;
  logic [1:0]  tx_pos_r;
  logic        again_r;
  logic        topo_wr_r;
  logic [1:0]  rx_pos_r;
  logic        tx_v_r;
  logic        tx_sop_r;
  char_t       tx_d_r;
  logic        refused_r;
  logic        rx_v_r;
  char_t       rx_d_r;
  logic        flush_r;
  logic        ready_r;
  logic        accept;
  logic        refuse;
  logic        pkt_end;

  // Dual topology or down claim only when the board is wired for it
  assign refuse = CMD_VALID && (state_r == ST_IDLE) && !DUAL_WIRED &&
    ((CMD_CODE == `CMD_CLAIM_DOWN) || (is_write(CMD_CODE) &&
     (CMD_DATA[`WD_TOPO_MSB:`WD_TOPO_LSB] == TOPO_DUAL)));
  assign accept = CMD_VALID && (state_r == ST_IDLE) && !refuse;
  assign pkt_end = (state_r == ST_SEND) && (tx_pos_r == `POS_DATA);

  // Command sequencer; the host starts every command packet
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      tx_pos_r <= 2'h0;
      again_r <= 1'b0;
      topo_wr_r <= 1'b0;
      ready_r <= 1'b1;
      code_r <= 8'h00;
      addr_r <= 8'h00;
      data_r <= 8'h00;
    end else if (accept) begin
      state_r <= ST_SEND;
      ready_r <= 1'b0;
      tx_pos_r <= 2'h0;
      code_r <= CMD_CODE;
      addr_r <= {3'h0, CMD_ADDR};
      data_r <= CMD_DATA;
      topo_wr_r <= is_write(CMD_CODE);
      // Internal loopback write is repeated to confirm it took
      again_r <= is_write(CMD_CODE) &&
        (CMD_DATA[`WD_TOPO_MSB:`WD_TOPO_LSB] == TOPO_INT_LOOP);
    end else if (pkt_end) begin
      tx_pos_r <= 2'h0;
      again_r <= 1'b0;
      state_r <= again_r ? ST_SEND : ST_IDLE;
      ready_r <= !again_r;
    end else if (state_r == ST_SEND) begin
      tx_pos_r <= tx_pos_r + 2'h1;
    end
  end

  // Transmit characters: command, address, data
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_v_r <= 1'b0;
      tx_sop_r <= 1'b0;
      tx_d_r <= 8'h00;
    end else begin
      tx_v_r <= (state_r == ST_SEND);
      tx_sop_r <= (state_r == ST_SEND) && (tx_pos_r == 2'h0);
      unique case (tx_pos_r)
        2'h0:    tx_d_r <= code_r;
        2'h1:    tx_d_r <= addr_r;
        default: tx_d_r <= data_r;
      endcase
    end
  end

  // Flush before a topology change and again after it is sent
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= (accept && is_write(CMD_CODE)) ||
                 (pkt_end && topo_wr_r);
    end
  end

  // Receive: third character of each returned packet is the answer
  always_ff @(posedge CORE_CLK) begin
    if (RST || flush_r) begin
      rx_pos_r <= `POS_DONE;
      rx_v_r <= 1'b0;
      rx_d_r <= 8'h00;
    end else begin
      rx_v_r <= LINK.d2h_valid && !LINK.d2h_sop &&
                (rx_pos_r == `POS_DATA);
      if (LINK.d2h_valid) begin
        rx_d_r <= LINK.d2h_data;
        if (LINK.d2h_sop) begin
          rx_pos_r <= `POS_ADDR;
        end else if (rx_pos_r != `POS_DONE) begin
          rx_pos_r <= rx_pos_r + 2'h1;
        end
      end
    end
  end

  // Refusal pulse
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= refuse;
    end
  end

  assign LINK.h2d_valid = tx_v_r;
  assign LINK.h2d_sop = tx_sop_r;
  assign LINK.h2d_data = tx_d_r;
  // Ready has its own flop that mirrors the idle state
  assign CMD_READY = ready_r;
  assign CMD_REFUSED = refused_r;
  assign RX_VALID = rx_v_r;
  assign RX_DATA = rx_d_r;
  assign RX_FLUSH = flush_r;

endmodule // chain_host

//--- verif/chain_link_assertions.sv
// Concurrent checks on the chain link and the lowest device's paths
`timescale 1ns/1ps
`include "chain_link_defines.svh"
module chain_link_assertions (
  input wire logic                 CORE_CLK,          // Clock
  input wire logic                 RST,               // Sync reset
  input wire logic                 h2d_valid,         // Host char
  input wire logic                 h2d_sop,           // Host start
  input wire chain_pkg::char_t     h2d_data,          // Host data
  input wire logic                 d2h_valid,         // Device char
  input wire logic                 d2h_sop,           // Device start
  input wire chain_pkg::char_t     d2h_data,          // Device data
  input wire logic                 RXU_VALID,         // Upper rx
  input wire chain_pkg::char_t     RXU_DATA,          // Upper rx data
  input wire logic                 TXU_VALID,         // Upper tx
  input wire logic                 TXU_SOP,           // Upper tx start
  input wire chain_pkg::char_t     TXU_DATA,          // Upper tx data
  input wire chain_pkg::topology_t LINK_TOPOLOGY,     // Topology
  input wire logic                 SLAVE_WRITE_ALERT, // Sticky alert
  input wire logic                 MASTER_PATH_FLAG   // Master path
);
  import chain_pkg::*;

  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Up path position; the data char of a read may carry a status reply
  logic [1:0] up_pos_r;
  logic       up_read_r;
  logic       reply_char;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      up_pos_r <= `POS_DONE;
      up_read_r <= 1'b0;
    end else if (h2d_valid) begin
      if (h2d_sop) begin
        up_pos_r <= `POS_ADDR;
        up_read_r <= (h2d_data == `CMD_READ);
      end else if (up_pos_r != `POS_DONE) begin
        up_pos_r <= up_pos_r + 2'h1;
      end
    end
  end
  assign reply_char = h2d_valid && !h2d_sop && up_read_r &&
                      (up_pos_r == `POS_DATA);

  // Up path repeats every host char one cycle later
  up_forward_a: assert property (
    h2d_valid |=> TXU_VALID && TXU_SOP == $past(h2d_sop)
      && (TXU_DATA == $past(h2d_data) || $past(reply_char)))
    else $error("up path char not forwarded");
  // Devices never start up-path traffic of their own
  up_quiet_a: assert property (
    !h2d_valid |=> !TXU_VALID)
    else $error("up path char without host char");
  // Host sends whole three-char packets
  host_frame_a: assert property (
    h2d_sop |-> h2d_valid ##1 (h2d_valid && !h2d_sop) [*2])
    else $error("host packet not three chars");
  // Pass-through down path copies the upper receiver
  pass_down_a: assert property (
    LINK_TOPOLOGY == TOPO_EXT_LOOP && RXU_VALID
      |=> d2h_valid && d2h_data == $past(RXU_DATA))
    else $error("down path char not passed through");
  // Internal loop feeds upper transmit, not the pins, downward
  int_loop_a: assert property (
    LINK_TOPOLOGY == TOPO_INT_LOOP && TXU_VALID |=> d2h_valid
      && d2h_sop == $past(TXU_SOP) && d2h_data == $past(TXU_DATA))
    else $error("internal loop char lost");
  // Alert topology sends the alert char while the flag is set
  alert_path_a: assert property (
    LINK_TOPOLOGY == TOPO_ALERT && SLAVE_WRITE_ALERT
      |=> d2h_valid && d2h_sop && d2h_data == `ALERT_CHAR)
    else $error("alert char missing");
  alert_quiet_a: assert property (
    LINK_TOPOLOGY == TOPO_ALERT && !SLAVE_WRITE_ALERT |=> !d2h_valid)
    else $error("alert path busy without alert");
  // State only moves after a char has been taken on some path
  alert_sticky_a: assert property (
    $fell(SLAVE_WRITE_ALERT) |-> $past(h2d_valid) || $past(RXU_VALID)
      || $past(RST))
    else $error("alert cleared without a command");
  topo_cause_a: assert property (
    !$stable(LINK_TOPOLOGY) |-> $past(h2d_valid) || $past(RXU_VALID)
      || $past(RST))
    else $error("topology changed without a command");

  // Main scenarios reached
  cover property (LINK_TOPOLOGY == TOPO_DUAL && SLAVE_WRITE_ALERT);
  cover property (MASTER_PATH_FLAG && RXU_VALID);
  cover property (LINK_TOPOLOGY == TOPO_INT_LOOP && TXU_VALID);
endmodule // chain_link_assertions

//--- verif/test_daisy_chain_uart_path_config.sv
// Self-checking bench: host and device joined by the chain link
`timescale 1ns/1ps
`include "chain_link_defines.svh"
module test_daisy_chain_uart_path_config;
  import chain_pkg::*;
  typedef struct packed {
    char_t     code;
    dev_addr_t addr;
    char_t     data;
    logic      has_rx;
    char_t     exp;
  } row_t;
  localparam dev_addr_t self_addr = 5'h0b;
  // External loopback traffic: request and the reply it should give
  row_t rows [7] = '{
    '{`CMD_READ,       self_addr, 8'h00, 1'b1, 8'h00},
    '{`CMD_READ,       5'h1f,     8'h5a, 1'b1, 8'h5a},
    '{`CMD_READ_ALL,   5'h1f,     8'h3c, 1'b1, 8'h3c},
    '{`CMD_BLOCK_READ, 5'h1f,     8'hc3, 1'b1, 8'hc3},
    '{`CMD_WRITE_ALL,  5'h1f,     8'h04, 1'b0, 8'h00},
    '{`CMD_WRITE,      self_addr, 8'h04, 1'b0, 8'h00},
    '{`CMD_READ,       self_addr, 8'h00, 1'b1, 8'h00}};
  logic      core_clk = 1'b0;
  logic      rst = 1'b1;
  logic      cmd_valid = 1'b0;
  char_t     cmd_code = 8'h00;
  dev_addr_t cmd_addr = 5'h00;
  char_t     cmd_data = 8'h00;
  logic      dual_wired = 1'b0;
  logic      rxu_valid = 1'b0;
  logic      rxu_sop = 1'b0;
  char_t     rxu_data = 8'h00;
  logic      cmd_ready, cmd_refused, rx_valid, txu_valid, txu_sop;
  logic      alert, master, rx_flush;
  char_t     rx_data, txu_data;
  topology_t topo;
  logic      got_rx = 1'b0;
  logic      got_ref = 1'b0;
  logic      got_flush = 1'b0;
  char_t     rx_last = 8'h00;
  int        mode = 0;    // 0 quiet, 1 loop cable, 2 noise
  int        err_count = 0;
  int        checks = 0;

  chain_link_if link ();
  chain_host u_chain_host (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_ADDR(cmd_addr),
    .CMD_DATA(cmd_data), .DUAL_WIRED(dual_wired), .CMD_READY(cmd_ready),
    .CMD_REFUSED(cmd_refused), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_FLUSH(rx_flush));
  chain_device u_chain_device (.CORE_CLK(core_clk), .RST(rst),
    .LINK(link), .DEV_ADDR(self_addr), .RXU_VALID(rxu_valid),
    .RXU_SOP(rxu_sop), .RXU_DATA(rxu_data), .TXU_VALID(txu_valid),
    .TXU_SOP(txu_sop), .TXU_DATA(txu_data), .LINK_TOPOLOGY(topo),
    .SLAVE_WRITE_ALERT(alert), .MASTER_PATH_FLAG(master));
  chain_link_assertions u_chain_link_assertions (.CORE_CLK(core_clk),
    .RST(rst), .h2d_valid(link.h2d_valid), .h2d_sop(link.h2d_sop),
    .h2d_data(link.h2d_data), .d2h_valid(link.d2h_valid),
    .d2h_sop(link.d2h_sop), .d2h_data(link.d2h_data),
    .RXU_VALID(rxu_valid), .RXU_DATA(rxu_data), .TXU_VALID(txu_valid),
    .TXU_SOP(txu_sop), .TXU_DATA(txu_data), .LINK_TOPOLOGY(topo),
    .SLAVE_WRITE_ALERT(alert), .MASTER_PATH_FLAG(master));

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  // Top of chain: loop cable, or noise the device must ignore
  always @(negedge core_clk) begin
    if (mode == 1) begin
      rxu_valid <= txu_valid;
      rxu_sop   <= txu_sop;
      rxu_data  <= txu_valid ? txu_data : ~rxu_data;
    end else if (mode == 2) begin
      rxu_valid <= 1'b1;
      rxu_sop   <= 1'b1;
      rxu_data  <= ~rxu_data;
    end
  end

  // Latch one-cycle pulses so the tasks can look later
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      got_rx  <= 1'b1;
      rx_last <= rx_data;
    end
    if (cmd_refused === 1'b1)
      got_ref <= 1'b1;
    if (rx_flush === 1'b1)
      got_flush <= 1'b1;
  end

  // Compare helpers; each call counts one comparison
  task automatic chk_char(input string what, input char_t exp,
                          input char_t got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // Request held to one edge with ready high, then wait for idle
  task automatic host_cmd(input char_t code, input dev_addr_t addr,
                          input char_t data);
    @(negedge core_clk);
    got_ref = 1'b0;
    got_flush = 1'b0;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_addr = addr;
    cmd_data = data;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (int n = 0; n < 40 && cmd_ready !== 1'b1; n++)
      @(negedge core_clk);
    // Chars cross each device in one cycle, so ten is ample
    repeat (10) @(negedge core_clk);
  endtask

  // Down-path packet from the top of the chain
  task automatic down_pkt(input char_t code, input dev_addr_t addr,
                          input char_t data);
    char_t p [3];
    p = '{code, {3'h0, addr}, data};
    for (int i = 0; i < 3; i++) begin
      @(negedge core_clk);
      rxu_valid = 1'b1;
      rxu_sop = (i == 0);
      rxu_data = p[i];
    end
    @(negedge core_clk);
    rxu_valid = 1'b0;
    rxu_data = ~data;
    repeat (6) @(negedge core_clk);
  endtask

  // Send a packet on either path and compare the host's reply
  task automatic ask(input logic down, input char_t code,
                     input dev_addr_t addr, input char_t data,
                     input char_t exp);
    got_rx = 1'b0;
    if (down)
      down_pkt(code, addr, data);
    else
      host_cmd(code, addr, data);
    for (int n = 0; n < 20 && got_rx !== 1'b1; n++)
      @(negedge core_clk);
    chk_char("reply", exp, got_rx ? rx_last : 8'hxx);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    row_t r;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk_char("topology", 8'h00, {6'h00, topo});
    chk_bit("alert", 1'b0, alert);
    chk_bit("master", 1'b0, master);
    chk_bit("ready", 1'b1, cmd_ready);
    $display("test reset done");
    mode = 1;
    foreach (rows[i]) begin
      r = rows[i];
      if (r.has_rx)
        ask(1'b0, r.code, r.addr, r.data, r.exp);
      else
        host_cmd(r.code, r.addr, r.data);
    end
    chk_bit("flush", 1'b0, got_flush);
    $display("test table done");
    // Without dual wiring, dual commands never leave the host
    host_cmd(`CMD_CLAIM_DOWN, self_addr, 8'h00);
    chk_bit("refused", 1'b1, got_ref);
    host_cmd(`CMD_WRITE, self_addr, 8'h03);
    chk_bit("refused", 1'b1, got_ref);
    chk_char("topology", 8'h00, {6'h00, topo});
    $display("test refuse done");
    mode = 2;
    host_cmd(`CMD_WRITE, self_addr, 8'h01);
    chk_bit("flush", 1'b1, got_flush);
    chk_char("topology", 8'h01, {6'h00, topo});
    ask(1'b0, `CMD_READ, self_addr, 8'h00, 8'h01);
    host_cmd(`CMD_WRITE, self_addr, 8'h00);
    @(posedge core_clk);
    mode = 1;
    $display("test loopback done");
    repeat (4) @(posedge core_clk);
    mode = 0;
    @(negedge core_clk);
    dual_wired = 1'b1;
    host_cmd(`CMD_WRITE, self_addr, 8'h03);
    chk_char("topology", 8'h03, {6'h00, topo});
    ask(1'b1, `CMD_WRITE, self_addr, 8'h04, 8'h04);
    chk_bit("alert", 1'b1, alert);
    chk_char("topology", 8'h03, {6'h00, topo});
    ask(1'b1, `CMD_READ, self_addr, 8'h00, 8'h07);
    host_cmd(`CMD_WRITE, self_addr, 8'h07);
    chk_bit("alert", 1'b0, alert);
    down_pkt(`CMD_CLAIM_UP, self_addr, 8'h00);
    chk_bit("alert", 1'b1, alert);
    chk_bit("master", 1'b0, master);
    down_pkt(`CMD_CLAIM_DOWN, self_addr, 8'h00);
    chk_bit("master", 1'b1, master);
    down_pkt(`CMD_WRITE, self_addr, 8'h07);
    chk_bit("alert", 1'b0, alert);
    host_cmd(`CMD_WRITE, self_addr, 8'h04);
    chk_char("topology", 8'h03, {6'h00, topo});
    chk_bit("alert", 1'b1, alert);
    host_cmd(`CMD_CLAIM_UP, self_addr, 8'h00);
    chk_bit("master", 1'b0, master);
    $display("test dual done");
    host_cmd(`CMD_WRITE, self_addr, 8'h02);
    chk_char("alert char", `ALERT_CHAR, link.d2h_data);
    chk_bit("alert start", 1'b1, link.d2h_sop);
    // Clear the alert but stay in alert topology: down path goes quiet
    host_cmd(`CMD_WRITE, self_addr, 8'h06);
    chk_char("topology", 8'h02, {6'h00, topo});
    chk_bit("down idle", 1'b0, link.d2h_valid);
    host_cmd(`CMD_WRITE, self_addr, 8'h04);
    mode = 1;
    ask(1'b0, `CMD_READ, self_addr, 8'h00, 8'h00);
    $display("test alert done");
    // Reset in mid-run from a non-default topology, then traffic at once
    host_cmd(`CMD_WRITE, self_addr, 8'h02);
    chk_char("topology", 8'h02, {6'h00, topo});
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    chk_char("topology", 8'h00, {6'h00, topo});
    chk_bit("alert", 1'b0, alert);
    chk_bit("master", 1'b0, master);
    chk_bit("ready", 1'b1, cmd_ready);
    ask(1'b0, `CMD_READ, self_addr, 8'h00, 8'h00);
    $display("test mid reset done");
    test_done();
  end

  // Run needs about 400 cycles; over thirty times that means a hang
  initial begin
    repeat (15000) @(posedge core_clk);
    err_count++;
    test_done();
  end
endmodule // test_daisy_chain_uart_path_config
